// ### mac_model.sv
// Purpose: mac side model driving mii transmit
// Assumes: nibble times marked by mii_stb_i
// Notes: holds enable as long as asked, so jabber can be provoked
`timescale 1ns/1ps
module mac_model
(
    // clock and nibble strobe
    input wire mclk_i,
    input wire mii_stb_i,
    // request from the bench
    input wire send_i,
    // mii transmit
    output logic tx_en_o,
    output logic tx_er_o,
    output logic [3:0] txd_o
);
    initial
    begin
        tx_en_o = 1'b0;
        tx_er_o = 1'b0;
        txd_o = 4'h0;
    end
    // step on the falling edge so the phy samples settled levels
    always @(negedge mclk_i)
        if (mii_stb_i)
        begin
            tx_en_o <= send_i; // dropping enable ends a jabber
            txd_o <= send_i ? txd_o + 4'h1 : 4'h0;
        end
endmodule // mac_model

// ### nibble_fifo.v
// Purpose: small synchronous fifo for receive nibbles
// Assumes: one clock, asynchronous active high reset
// Notes: read data comes from a register; rd_valid_o holds it until taken
`timescale 1ns/1ps
module nibble_fifo #(
    parameter WIDTH = 6,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // fill side
    input wire wr_valid_i,
    input wire [WIDTH-1:0] wr_data_i,
    output wire wr_ready_o,
    // drain side
    output reg rd_valid_o,
    output reg [WIDTH-1:0] rd_data_o,
    input wire rd_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wptr;
    reg [AW:0] rptr;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;

    // pointers carry one extra bit to tell full from empty
    assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    assign empty = (wptr == rptr);
    assign wr_ready_o = ~full;
    assign do_wr = wr_valid_i & ~full;
    assign do_rd = ~empty & (~rd_valid_o | rd_ready_i);

    // storage write
    always @(posedge mclk_i)
    begin
        if (do_wr)
            mem[wptr[AW-1:0]] <= wr_data_i;
    end

    // pointers and output register
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
            rd_valid_o <= 1'b0;
            rd_data_o <= {WIDTH{1'b0}};
        end
        else
        begin
            if (do_wr)
                wptr <= wptr + 1'b1;
            if (do_rd)
            begin
                rd_data_o <= mem[rptr[AW-1:0]];
                rptr <= rptr + 1'b1;
                rd_valid_o <= 1'b1;
            end
            else if (rd_ready_i)
                rd_valid_o <= 1'b0;
        end
    end
endmodule // nibble_fifo

// ### phy_line_coding_path.v
// Purpose: digital line coding path of one 10/100 phy port
// Assumes: all inputs synchronous to mclk_i; 100M side steps on sym_stb_i,
//          10M side on bit10_stb_i (20 MHz half-bit strobe), mii on mii_stb_i
// Notes: scrambler/descrambler use the 11-bit stream cipher x^11+x^9+1
`timescale 1ns/1ps
`include "phy_line_coding_regs.vh"
module phy_line_coding_path #(
    parameter JABBER_CYC = `JABBER_CYC,
    parameter NLP_CYC = `NLP_CYC,
    parameter NLP_TO_CYC = `NLP_TO_CYC,
    parameter IDLE_WIN_CYC = `IDLE_WIN_CYC,
    parameter FIFO_DEPTH = 8
)
(
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // mode and timing strobes
    input wire speed100_i,
    input wire sym_stb_i,
    input wire bit10_stb_i,
    input wire mii_stb_i,
    // mii transmit from the mac
    input wire tx_en_i,
    input wire tx_er_i,
    input wire [3:0] txd_i,
    // mii receive to the mac
    output reg rx_dv_o,
    output reg rx_er_o,
    output reg crs_o,
    output reg [3:0] rxd_o,
    // line transmit, 100M mlt-3 level and 10M differential
    output reg line_tx_positive,
    output reg line_tx_negative,
    // line receive: mlt-3 level (-1,0,+1 as 2 bits) and 10M differential
    input wire [1:0] mlt3_rx_i,
    input wire line_rx_positive,
    input wire line_rx_negative,
    // status
    output reg [7:0] special_status_indication_reg,
    output reg link10_up_o,
    output reg jabber_o
);
    // 5b to 4b decode; bit 4 of the result flags a non-data group
    function [4:0] dec5;
        input [4:0] cg;
        begin
            case (cg)
                5'h1E: dec5 = 5'h00;
                5'h09: dec5 = 5'h01;
                5'h14: dec5 = 5'h02;
                5'h15: dec5 = 5'h03;
                5'h0A: dec5 = 5'h04;
                5'h0B: dec5 = 5'h05;
                5'h0E: dec5 = 5'h06;
                5'h0F: dec5 = 5'h07;
                5'h12: dec5 = 5'h08;
                5'h13: dec5 = 5'h09;
                5'h16: dec5 = 5'h0A;
                5'h17: dec5 = 5'h0B;
                5'h1A: dec5 = 5'h0C;
                5'h1B: dec5 = 5'h0D;
                5'h1C: dec5 = 5'h0E;
                5'h1D: dec5 = 5'h0F;
                default: dec5 = 5'h10;
            endcase
        end
    endfunction

    // 4b to 5b encode
    function [4:0] enc4;
        input [3:0] n;
        reg [79:0] tbl;
        begin
            tbl = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
                   5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
            enc4 = tbl[n*5 +: 5];
        end
    endfunction

    // transmit side, 100M
    localparam TX_IDLE = 3'h0;
    localparam TX_J = 3'h1;
    localparam TX_K = 3'h2;
    localparam TX_DATA = 3'h3;
    localparam TX_T = 3'h4;
    localparam TX_R = 3'h5;
    reg [2:0] tx_state;
    reg [4:0] tx_cg;
    reg [4:0] tx_shift;
    reg [2:0] tx_bit;
    reg [10:0] scr;
    reg nrzi_tx;
    reg [1:0] mlt_phase;
    reg [31:0] jab_cnt;
    wire scr_bit;
    wire tx_out_bit;
    wire tx_allowed;

    assign tx_allowed = tx_en_i & ~jabber_o;
    assign scr_bit = scr[10] ^ scr[8];
    assign tx_out_bit = tx_shift[4] ^ scr_bit;

    // choose the next code group on the last bit of the current one
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_state <= TX_IDLE;
            tx_cg <= `CG_IDLE;
            tx_shift <= `CG_IDLE;
            tx_bit <= 3'h0;
            scr <= 11'h7FF;
            nrzi_tx <= 1'b0;
            mlt_phase <= 2'h0;
        end
        else if (sym_stb_i && speed100_i)
        begin
            scr <= {scr[9:0], scr_bit};
            // nrzi: a one toggles the stream
            nrzi_tx <= nrzi_tx ^ tx_out_bit;
            // mlt-3 steps 0,+,0,- on every one bit
            if (tx_out_bit)
                mlt_phase <= mlt_phase + 2'h1;
            if (tx_bit == 3'h4)
            begin
                tx_bit <= 3'h0;
                case (tx_state)
                    TX_IDLE:
                    begin
                        if (tx_allowed)
                        begin
                            tx_state <= TX_J;
                            tx_shift <= `CG_J;
                        end
                        else
                            tx_shift <= `CG_IDLE;
                    end
                    TX_J:
                    begin
                        tx_state <= TX_K;
                        tx_shift <= `CG_K;
                    end
                    TX_K, TX_DATA:
                    begin
                        if (tx_allowed)
                        begin
                            tx_state <= TX_DATA;
                            tx_shift <= tx_er_i ? `CG_H : enc4(txd_i);
                        end
                        else
                        begin
                            tx_state <= TX_T;
                            tx_shift <= `CG_T;
                        end
                    end
                    TX_T:
                    begin
                        tx_state <= TX_R;
                        tx_shift <= `CG_R;
                    end
                    default:
                    begin
                        tx_state <= TX_IDLE;
                        tx_shift <= `CG_IDLE;
                    end
                endcase
            end
            else
            begin
                tx_bit <= tx_bit + 3'h1;
                tx_shift <= {tx_shift[3:0], 1'b0};
            end
        end
    end

    // jabber timer; released by the mac dropping tx_en
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            jab_cnt <= 32'h0;
            jabber_o <= 1'b0;
        end
        else
        begin
            if (!tx_en_i)
            begin
                jab_cnt <= 32'h0;
                jabber_o <= 1'b0;
            end
            else if (jab_cnt >= JABBER_CYC - 1)
                jabber_o <= 1'b1;
            else
                jab_cnt <= jab_cnt + 32'h1;
        end
    end

    // 10M transmit: nibble serialiser, manchester coder, link pulses
    reg [3:0] t10_nib;
    reg [1:0] t10_bit;
    reg t10_half;
    reg t10_act;
    reg [31:0] nlp_cnt;
    reg [7:0] nlp_w;
    wire [31:0] nlp_w_full;
    assign nlp_w_full = `NLP_WIDTH_CYC;
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            t10_nib <= 4'h0;
            t10_bit <= 2'h0;
            t10_half <= 1'b0;
            t10_act <= 1'b0;
            nlp_cnt <= 32'h0;
            nlp_w <= 8'h0;
            line_tx_positive <= 1'b0;
            line_tx_negative <= 1'b0;
        end
        else if (speed100_i)
        begin
            // differential view of the mlt-3 level
            line_tx_positive <= (mlt_phase == 2'h1);
            line_tx_negative <= (mlt_phase == 2'h3);
        end
        else
        begin
            if (nlp_w != 8'h0)
                nlp_w <= nlp_w - 8'h1;
            if (bit10_stb_i && t10_act)
            begin
                // manchester: first half inverted, second half true
                line_tx_positive <= t10_half ? t10_nib[t10_bit] : ~t10_nib[t10_bit];
                line_tx_negative <= t10_half ? ~t10_nib[t10_bit] : t10_nib[t10_bit];
                t10_half <= ~t10_half;
                if (t10_half)
                begin
                    t10_bit <= t10_bit + 2'h1;
                    if (t10_bit == 2'h3)
                    begin
                        t10_act <= tx_allowed;
                        t10_nib <= txd_i;
                    end
                end
            end
            else if (!t10_act)
            begin
                t10_act <= tx_allowed & mii_stb_i;
                t10_nib <= txd_i;
                t10_bit <= 2'h0;
                t10_half <= 1'b0;
                // idle line carries a pulse every 16 ms
                if (nlp_cnt >= NLP_CYC - 1)
                begin
                    nlp_cnt <= 32'h0;
                    nlp_w <= nlp_w_full[7:0];
                end
                else
                    nlp_cnt <= nlp_cnt + 32'h1;
                line_tx_positive <= (nlp_w != 8'h0);
                line_tx_negative <= 1'b0;
            end
        end
    end

    // 100M receive: mlt-3 to nrzi, nrzi to bit, descramble
    reg [1:0] mlt_prev;
    reg nrzi_rx;
    reg [10:0] dscr;
    reg [9:0] idle_run;
    reg locked;
    reg [31:0] win_cnt;
    reg [9:0] rx_hist;
    wire line_bit;
    wire key_bit;
    wire plain_bit;
    assign line_bit = (mlt3_rx_i != mlt_prev);
    assign key_bit = dscr[10] ^ dscr[8];
    assign plain_bit = line_bit ^ key_bit;

    // key loading during idle, free-run once locked
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mlt_prev <= 2'h0;
            nrzi_rx <= 1'b0;
            dscr <= 11'h0;
            idle_run <= 10'h0;
            locked <= 1'b0;
            win_cnt <= 32'h0;
        end
        else if (sym_stb_i && speed100_i)
        begin
            mlt_prev <= mlt3_rx_i;
            nrzi_rx <= line_bit;
            // an all-ones plain stream is idle; unlocked, the inverted line bit is the key
            dscr <= {dscr[9:0], locked ? key_bit : ~line_bit};
            idle_run <= plain_bit ? ((idle_run == 10'h3FF) ? idle_run : idle_run + 10'h1) : 10'h0;
            if (idle_run >= 10'd60)
            begin
                locked <= 1'b1;
                win_cnt <= 32'h0;
            end
            else if (win_cnt >= IDLE_WIN_CYC - 1)
            begin
                locked <= 1'b0;
                win_cnt <= 32'h0;
            end
            else
                win_cnt <= win_cnt + 32'h1;
        end
    end

    // alignment and decode
    localparam RX_IDLE = 2'h0;
    localparam RX_K = 2'h1;
    localparam RX_DATA = 2'h2;
    localparam RX_END = 2'h3;
    reg [1:0] rx_state;
    reg [2:0] rx_cnt;
    reg [5:0] fifo_in;
    reg fifo_wr;
    reg rx_frame;
    reg pre_pend;
    wire [4:0] grp;
    wire [4:0] dec;
    wire fifo_ready;
    wire fifo_vld;
    wire [5:0] fifo_out;
    assign grp = rx_hist[4:0];
    assign dec = dec5(grp);

    // j-k finds group boundary, kept until the next frame
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_hist <= 10'h3FF;
            rx_state <= RX_IDLE;
            rx_cnt <= 3'h0;
            fifo_in <= 6'h0;
            pre_pend <= 1'b0;
            fifo_wr <= 1'b0;
            rx_frame <= 1'b0;
        end
        else
        begin
            // second preamble nibble rides one cycle behind the first
            fifo_wr <= pre_pend;
            pre_pend <= 1'b0;
            if (sym_stb_i && speed100_i)
            begin
                rx_hist <= {rx_hist[8:0], plain_bit};
                rx_cnt <= (rx_cnt == 3'h4) ? 3'h0 : rx_cnt + 3'h1;
                if (!locked || !fifo_ready)
                begin
                    // lost sync or stalled mac aborts the frame
                    rx_state <= RX_IDLE;
                    rx_frame <= 1'b0;
                end
                else
                begin
                    case (rx_state)
                        RX_IDLE:
                        begin
                            if ({rx_hist[8:0], plain_bit} == {`CG_IDLE, `CG_J})
                            begin
                                rx_state <= RX_K;
                                rx_cnt <= 3'h0;
                            end
                        end
                        RX_K:
                        begin
                            if (rx_cnt == 3'h4)
                            begin
                                fifo_wr <= 1'b1;
                                if ({rx_hist[3:0], plain_bit} == `CG_K)
                                begin
                                    fifo_in <= {2'b10, `NIB_PREAMBLE};
                                    rx_state <= RX_DATA;
                                    rx_frame <= 1'b1;
                                    pre_pend <= 1'b1;
                                end
                                else
                                begin
                                    // bad start, dv stays low
                                    fifo_in <= {2'b01, `NIB_BAD_SSD};
                                    rx_state <= RX_IDLE;
                                end
                            end
                        end
                        RX_DATA:
                        begin
                            if (rx_cnt == 3'h4)
                            begin
                                rx_hist[4:0] <= {rx_hist[3:0], plain_bit};
                                if ({rx_hist[3:0], plain_bit} == `CG_T ||
                                    {rx_hist[3:0], plain_bit} == `CG_IDLE)
                                    rx_state <= RX_END;
                                else
                                begin
                                    // invalid group flags error
                                    fifo_wr <= 1'b1;
                                    fifo_in <= {1'b1, dec5({rx_hist[3:0], plain_bit})};
                                end
                            end
                        end
                        default:
                        begin
                            if (rx_cnt == 3'h4)
                            begin
                                // t-r or two idles close the frame
                                rx_state <= RX_IDLE;
                                rx_frame <= 1'b0;
                                if ({rx_hist[3:0], plain_bit} != `CG_R &&
                                    {rx_hist[3:0], plain_bit} != `CG_IDLE)
                                begin
                                    fifo_wr <= 1'b1;
                                    fifo_in <= {2'b11, 4'h0};
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    // 10M receive: polarity, link pulses, nibble assembly
    reg [3:0] r10_nib;
    reg [1:0] r10_bit;
    reg [31:0] nlp_to;
    reg rx_p_d;
    reg pol_rev;
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            r10_nib <= 4'h0;
            r10_bit <= 2'h0;
            nlp_to <= 32'h0;
            rx_p_d <= 1'b0;
            pol_rev <= 1'b0;
            link10_up_o <= 1'b0;
            special_status_indication_reg <= 8'h00;
        end
        else
        begin
            rx_p_d <= line_rx_positive;
            special_status_indication_reg[`STAT_POL_BIT] <= pol_rev;
            // a link pulse arrives as a positive then idle; a negative pulse means swapped pairs
            if (line_rx_negative && !line_rx_positive && !rx_frame && !speed100_i)
                pol_rev <= 1'b1;
            else if (line_rx_positive && !line_rx_negative && !rx_frame && !speed100_i && !rx_p_d)
                pol_rev <= 1'b0;
            // a pulse counts only in the corrected polarity
            if ((pol_rev ? line_rx_negative : line_rx_positive) && !(pol_rev ? line_rx_positive : line_rx_negative))
            begin
                nlp_to <= 32'h0;
                link10_up_o <= 1'b1;
            end
            else if (nlp_to >= NLP_TO_CYC - 1)
                link10_up_o <= 1'b0;
            else
                nlp_to <= nlp_to + 32'h1;
            // second half of each bit cell carries the true value
            if (bit10_stb_i && !speed100_i)
            begin
                r10_nib[r10_bit] <= line_rx_positive ^ pol_rev;
                r10_bit <= r10_bit + 2'h1;
            end
        end
    end

    // mii side drains the fifo at one nibble per strobe
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            crs_o <= 1'b0;
            rxd_o <= 4'h0;
        end
        else if (mii_stb_i)
        begin
            crs_o <= rx_frame;
            if (fifo_vld)
            begin
                rx_dv_o <= fifo_out[5];
                rx_er_o <= fifo_out[4];
                rxd_o <= fifo_out[3:0];
            end
            else
            begin
                rx_dv_o <= 1'b0;
                rx_er_o <= 1'b0;
                rxd_o <= 4'h0;
            end
        end
    end

    // receive buffer between symbol rate and mii rate
    nibble_fifo #(
        .WIDTH(6),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wr_valid_i(fifo_wr),
        .wr_data_i(fifo_in),
        .wr_ready_o(fifo_ready),
        .rd_valid_o(fifo_vld),
        .rd_data_o(fifo_out),
        .rd_ready_i(mii_stb_i)
    );
endmodule // phy_line_coding_path

// ### phy_line_coding_path_chk.sv
// Purpose: port assertions for the line coding path
// Assumes: one clock mclk_i, asynchronous active high rst_i
// Notes: long waits are counted in helper logic
`timescale 1ns/1ps
module phy_line_coding_path_chk #(parameter JABBER_CYC = 200, parameter NLP_CYC = 100)
(
    // clock, reset and controls (grouped to keep the file short)
    input wire mclk_i, rst_i, speed100_i, mii_stb_i, tx_en_i,
    // observed outputs
    input logic rx_dv_o, rx_er_o, crs_o, line_tx_positive, line_tx_negative, jabber_o,
    input logic [3:0] rxd_o
);
    int en_cnt;
    int gap_cnt;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // run length of tx enable and of the quiet 10M line; en_cnt saturates so it cannot wrap
    always @(posedge mclk_i or posedge rst_i)
        if (rst_i)
        begin
            en_cnt <= 0;
            gap_cnt <= 0;
        end
        else
        begin
            en_cnt <= tx_en_i ? en_cnt + (en_cnt < 100000) : 0;
            gap_cnt <= (speed100_i || tx_en_i || line_tx_positive) ? 0 : gap_cnt + 1;
        end
    sequence s_jab_release;
        jabber_o && !tx_en_i;
    endsequence
    a_rx_hold_stable: assert property (!$past(mii_stb_i) |-> $stable({rx_dv_o, rx_er_o, crs_o, rxd_o}))
        else $error("receive outputs moved without a nibble strobe");
    a_ssd_err_nibble: assert property (rx_er_o && !rx_dv_o |-> rxd_o == 4'hE)
        else $error("error outside a frame without nibble E");
    a_dv_starts_pre: assert property ($rose(rx_dv_o) |-> rxd_o == 4'h5)
        else $error("frame did not open with preamble nibble");
    a_dv_needs_crs: assert property (rx_dv_o |-> crs_o)
        else $error("data valid without carrier");
    a_mlt3_no_jump: assert property (speed100_i && $past(speed100_i) |->
        !($past(line_tx_positive) && line_tx_negative) && !($past(line_tx_negative) && line_tx_positive))
        else $error("three level output skipped the middle level");
    a_jab_within: assert property (en_cnt >= JABBER_CYC + 16 |-> jabber_o)
        else $error("long enable not flagged as jabber");
    a_jab_release: assert property (s_jab_release |-> ##[1:16] !jabber_o)
        else $error("jabber not cleared after enable dropped");
    a_nlp_gap_max: assert property (gap_cnt < NLP_CYC + NLP_CYC + 40)
        else $error("idle 10M line without link pulse");
endmodule // phy_line_coding_path_chk
bind phy_line_coding_path phy_line_coding_path_chk #(.JABBER_CYC(JABBER_CYC), .NLP_CYC(NLP_CYC)) chk_i (
    .mclk_i, .rst_i, .speed100_i, .mii_stb_i, .tx_en_i, .rx_dv_o, .rx_er_o, .crs_o,
    .line_tx_positive, .line_tx_negative, .jabber_o, .rxd_o);

// ### phy_line_coding_path_tb.sv
// Purpose: self-checking bench for the line coding path
// Assumes: 200 MHz clock, shortened jabber and link pulse counts
// Notes: a small scrambler drives the 100M receive line
`timescale 1ns/1ps
`include "phy_line_coding_regs.vh"
module phy_line_coding_path_tb;
    localparam JAB = 200;
    localparam NLP = 100;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic speed100_i = 1'b0, sym_stb_i = 1'b0, bit10_stb_i = 1'b0, mii_stb_i = 1'b0, send = 1'b0;
    logic rxp = 1'b0, rxn = 1'b0;
    logic tx_en, tx_er, rx_dv, rx_er, crs, txp, txn, link_up, jab;
    logic [3:0] txd, rxd;
    logic [7:0] stat;
    logic [1:0] mlt = 2'h0;
    logic [10:0] lfsr = 11'h5A5;
    logic [15:0] rx_seen = 16'h0;
    logic er_seen = 1'b0;
    int miscompares = 0, n_tests = 0, cyc = 0, ph = 0;
    always #2.5 mclk_i = ~mclk_i;
    // rates are approximate: 200 MHz does not divide to 125 MHz
    always @(negedge mclk_i)
    begin
        ph <= ph + 1;
        sym_stb_i <= ph[0];
        bit10_stb_i <= (ph % 10 == 0);
        mii_stb_i <= (ph % (speed100_i ? 8 : 80) == 0);
    end
    // one look per nibble strobe at the receive side
    always @(negedge mclk_i)
        if (mii_stb_i && rx_dv)
        begin
            rx_seen <= {rx_seen[11:0], rxd};
            er_seen <= er_seen | rx_er;
        end
    mac_model mac_model_i (.mclk_i, .mii_stb_i, .send_i(send), .tx_en_o(tx_en), .tx_er_o(tx_er), .txd_o(txd));
    phy_line_coding_path #(.JABBER_CYC(JAB), .NLP_CYC(NLP), .NLP_TO_CYC(400), .IDLE_WIN_CYC(500))
        phy_line_coding_path_i (.mclk_i, .rst_i, .speed100_i, .sym_stb_i, .bit10_stb_i, .mii_stb_i,
        .tx_en_i(tx_en), .tx_er_i(tx_er), .txd_i(txd), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .crs_o(crs),
        .rxd_o(rxd), .line_tx_positive(txp), .line_tx_negative(txn), .mlt3_rx_i(mlt),
        .line_rx_positive(rxp), .line_rx_negative(rxn), .special_status_indication_reg(stat),
        .link10_up_o(link_up), .jabber_o(jab));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // cycles until the positive line next rises, after any pulse in progress ends
    task automatic wait_rise(input int lim, output int n);
        n = 0;
        while (txp === 1'b1 && n < lim)
        begin
            @(negedge mclk_i);
            n++;
        end
        n = 0;
        while (txp !== 1'b1 && n < lim)
        begin
            @(negedge mclk_i);
            n++;
        end
    endtask
    task automatic t_nlp_tx;
        int t0, t1;
        wait_rise(3 * NLP, t0);
        wait_rise(3 * NLP, t1);
        chk("first pulse seen", 8'h01, {7'h0, t0 < 3 * NLP});
        chk("pulse spacing", 8'h01, {7'h0, t1 >= NLP / 2 && t1 <= NLP + 30});
    endtask
    task automatic t_link_rx(input logic rev, input logic [7:0] exp_stat);
        repeat (6)
        begin
            {rxp, rxn} <= rev ? 2'b01 : 2'b10;
            repeat (20) @(negedge mclk_i);
            {rxp, rxn} <= 2'b00;
            repeat (NLP) @(negedge mclk_i);
        end
        chk("link up", 8'h01, {7'h0, link_up});
        chk("status polarity", exp_stat, stat);
    endtask
    // one code group, msb first, scrambled; a one moves the three-level line
    task automatic send_cg(input logic [4:0] cg);
        logic k;
        for (int i = 4; i >= 0; i--)
        begin
            k = lfsr[10] ^ lfsr[8];
            lfsr = {lfsr[9:0], k};
            if (cg[i] ^ k)
                mlt = mlt ^ 2'h1;
            repeat (2) @(negedge mclk_i);
        end
    endtask
    task automatic t_rx100;
        speed100_i <= 1'b1;
        repeat (20) send_cg(`CG_IDLE);
        send_cg(`CG_J);
        send_cg(`CG_K);
        send_cg(5'h0E);
        send_cg(5'h00);
        send_cg(`CG_T);
        send_cg(`CG_R);
        repeat (4) send_cg(`CG_IDLE);
        chk("preamble nibbles", 8'h55, rx_seen[15:8]);
        chk("data and bad nibble", 8'h60, rx_seen[7:0]);
        chk("error flagged", 8'h01, {7'h0, er_seen});
        chk("frame closed", 8'h00, {6'h0, rx_dv, crs});
    endtask
    task automatic t_jabber;
        speed100_i <= 1'b1;
        send <= 1'b1;
        repeat (JAB + 40) @(negedge mclk_i);
        chk("jabber set", 8'h01, {7'h0, jab});
        send <= 1'b0;
        repeat (24) @(negedge mclk_i);
        chk("jabber cleared", 8'h00, {7'h0, jab});
    endtask
    // ceiling far above the roughly 2500 cycles the scenarios need
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim;
        end
    end
    initial
    begin
        repeat (8) @(negedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        chk("receive after reset", 8'h00, {rx_dv, rx_er, crs, link_up, rxd});
        chk("status after reset", 8'h00, stat);
        t_nlp_tx;
        t_link_rx(1'b0, 8'h00);
        t_link_rx(1'b1, 8'h10);
        t_rx100;
        t_jabber;
        end_sim;
    end
endmodule // phy_line_coding_path_tb

// ### phy_line_coding_regs.vh
// Purpose: constants for the phy line coding path
// Assumes: 200 MHz mclk_i, period 5 ns
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef PHY_LINE_CODING_REGS_VH
`define PHY_LINE_CODING_REGS_VH

`define CLK_PERIOD_PS 5000
// code groups
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_IDLE 5'h1F
`define CG_T 5'h0D
`define CG_R 5'h07
`define CG_H 5'h04
// nibble driven on a bad start delimiter
`define NIB_BAD_SSD 4'hE
`define NIB_PREAMBLE 4'h5
// status bit position of the polarity flag
`define STAT_POL_BIT 4
// idle search window, 500 bytes at 100 Mb/s, 40 us
`define IDLE_WIN_US 40
`define IDLE_WIN_CYC ((`IDLE_WIN_US * 1000000) / `CLK_PERIOD_PS)
// jabber limit, 45 ms, rounded down
`define JABBER_MS 45
`define JABBER_CYC (`JABBER_MS * (1000000000 / `CLK_PERIOD_PS))
// link pulse spacing, 16 ms
`define NLP_MS 16
`define NLP_CYC (`NLP_MS * (1000000000 / `CLK_PERIOD_PS))
// 100 ns link pulse width
`define NLP_WIDTH_NS 100
`define NLP_WIDTH_CYC ((`NLP_WIDTH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// link pulse timeout for the receive side, 50 ms
`define NLP_TO_MS 50
`define NLP_TO_CYC (`NLP_TO_MS * (1000000000 / `CLK_PERIOD_PS))

`endif
